/* include/smp_regs.vh */
// constants for the external port and strap configuration block
// assumes a 200 MHz core clock
`ifndef SMP_REGS_VH
`define SMP_REGS_VH
// strap field positions in the captured strap word
`define SMP_STRAP_BKP_EN 0
`define SMP_STRAP_BKP_TYPE_LO 1
`define SMP_STRAP_BKP_TYPE_HI 2
`define SMP_STRAP_FLOW 3
`define SMP_STRAP_AGGR 4
`define SMP_STRAP_TEST 5
`define SMP_STRAP_W 6
// reset values of straps when nothing drives them (pull resistors)
`define SMP_STRAP_RESET 6'h19
// carrier-based backpressure code
`define SMP_BKP_CARRIER 2'h0
// fixed backoff figures
`define SMP_CARRIER_SENSE_BITS 7'h40
`define SMP_AGGR_MAX_SLOTS 4'h8
`define SMP_STD_MAX_SLOTS 11'h400
`define SMP_EXCESS_COLL 5'h10
// port clock divider: 200 MHz / 8 = 25 MHz
`define SMP_CLK_HALF_DIV 2'h3
`endif

/* tb/smp_mac_model.sv */
// behavioural external mac: sends one four-nibble frame on request
// assumes port_clk is the level seen on the shared port clock pin
`timescale 1ns/1ps
`default_nettype none
module smp_mac_model (
  input wire port_clk,
  input wire [15:0] frame,
  input wire go,
  output reg tx_en = 1'b0,
  output reg [3:0] tx_nibble = 4'h0
);
  reg [15:0] sh = 16'h0000;
  integer left = 0;
  // ==========================
  // transmit
  // launch on the falling edge so the device samples mid-bit
  always @(negedge port_clk) begin
    if (left > 0) begin
      tx_en <= 1'b1;
      tx_nibble <= sh[3:0];
      sh <= sh >> 4;
      left <= left - 1;
    end else begin
      // idle lines rest at the pull-low level
      tx_en <= 1'b0;
      tx_nibble <= 4'h0;
      if (go) begin
        sh <= frame;
        left <= 4;
      end
    end
  end
endmodule // smp_mac_model
`default_nettype wire

/* tb/smp_port_bench.sv */
// testbench for smp_port: config table, straps, tx and rx paths, collisions
// assumes smp_port, smp_mac_model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module smp_port_bench;
  reg clock = 1'b0, rst_n = 1'b0, external_port_enable = 1'b0, serial_mode = 1'b0;
  reg direct_led_mode = 1'b0, broadcast_limit_enable = 1'b0, excess_collision_drop = 1'b0;
  reg backpressure_enable_strap_in = 1'b0, flow_strap_in = 1'b0;
  reg test_pass_strap_in = 1'b0;
  reg aggressive_backoff_strap_in = 1'b1, core_rx_valid = 1'b0, core_collision = 1'b0;
  reg port4_link = 1'b0, port5_link = 1'b0, rx_is_broadcast = 1'b0, rx_frame_start = 1'b0;
  reg tx_collision = 1'b0, tx_frame_start = 1'b0, go = 1'b0, carrier_sense = 1'b0;
  reg [1:0] backpressure_type_strap_in = 2'h2;
  reg [3:0] core_rx_nibble = 4'h0;
  reg [7:0] bcast_queued = 8'h00;
  wire eeprom_serial_clock, eeprom_serial_clock_oe, port_rx_valid, port_rx_valid_oe;
  wire port_collision_out, port_collision_out_oe, port4_link_led, port4_link_led_oe;
  wire port5_link_led, port5_link_led_oe, port_tx_enable_in, core_tx_valid, core_tx_strobe;
  wire rx_drop, tx_discard, backoff_active, backpressure_enable, backpressure_carrier;
  wire flow_control_enable, aggressive_backoff, test_pass, carrier_window_fixed;
  wire backoff_carrier_seen;
  wire [1:0] backpressure_type;
  wire [3:0] port_rx_nibble, port_rx_nibble_oe, port_tx_nibble, core_tx_nibble;
  // pin falls to its pull-low level when the device lets go
  wire pclk_pin = eeprom_serial_clock_oe ? eeprom_serial_clock : 1'b0;
  wire [8:0] oes = {eeprom_serial_clock_oe, port_rx_nibble_oe, port_rx_valid_oe,
    port_collision_out_oe, port4_link_led_oe, port5_link_led_oe};
  wire [5:0] straps = {backpressure_enable, backpressure_type, flow_control_enable,
    aggressive_backoff, test_pass};
  wire [7:0] flags = {straps, backpressure_carrier, carrier_window_fixed};
  wire [7:0] rxp = {port_rx_nibble, port_rx_valid, port_collision_out, port4_link_led,
    port5_link_led};
  reg [22:0] rows [0:4];
  reg [3:0] got [0:3];
  integer errors = 0, n_tests = 0, i, k = 0, nd = 0, t0;

  smp_port dut (.*, .eeprom_data_in(1'b0));
  smp_mac_model mac (.port_clk(pclk_pin), .frame(16'h3c5a), .go(go),
    .tx_en(port_tx_enable_in), .tx_nibble(port_tx_nibble));

  // ==========================
  // helpers
  task check(input [15:0] got_v, input [15:0] exp_v);
    begin
      n_tests = n_tests + 1;
      if (got_v !== exp_v) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got_v, exp_v);
      end
    end
  endtask
  task stop_test;
    begin
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (core_tx_strobe === 1'b1 && k < 4) begin
      got[k] = core_tx_nibble;
      k = k + 1;
    end
    if (tx_discard === 1'b1) nd = nd + 1;
  end
  // fifteen backoffs of a few slots each, plus margin
  initial begin
    #500000;
    errors = errors + 1;
    stop_test;
  end

  // ==========================
  // sequence
  initial begin
    rows[0] = {5'h17, 8'h09, 9'h1ff, 1'b1};
    rows[1] = {5'h13, 8'h08, 9'h1fc, 1'b0};
    rows[2] = {5'h1a, 8'hff, 9'h118, 1'b0};
    rows[3] = {5'h05, 8'hff, 9'h003, 1'b0};
    rows[4] = {5'h1f, 8'hff, 9'h11b, 1'b1};
    repeat (2) @(posedge clock);
    #1;
    check({oes, straps}, 16'h0026);
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clock);
      {external_port_enable, serial_mode, direct_led_mode, broadcast_limit_enable,
        rx_is_broadcast, bcast_queued} <= rows[i][22:10];
      rx_frame_start <= 1'b1;
      @(posedge clock);
      rx_frame_start <= 1'b0;
      repeat (12) @(posedge clock);
      #1;
      check({oes, rx_drop}, rows[i][9:0]);
    end
    @(posedge clock);
    {backpressure_enable_strap_in, backpressure_type_strap_in, flow_strap_in,
      aggressive_backoff_strap_in, test_pass_strap_in} <= 6'h2c;
    serial_mode <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check(flags, 16'h0049);
    k = 0;
    @(posedge clock);
    go <= 1'b1;
    {core_rx_nibble, core_rx_valid, core_collision, port4_link} <= 7'h57;
    repeat (10) @(posedge clock);
    go <= 1'b0;
    for (t0 = 0; t0 < 300 && k < 4; t0 = t0 + 1) @(posedge clock);
    #1;
    check({got[3], got[2], got[1], got[0]}, 16'h3c5a);
    check(rxp, 16'h00ae);
    check(core_tx_valid, 16'h0001);
    k = 0;
    @(posedge clock);
    serial_mode <= 1'b1;
    go <= 1'b1;
    repeat (10) @(posedge clock);
    go <= 1'b0;
    for (t0 = 0; t0 < 300 && k < 4; t0 = t0 + 1) @(posedge clock);
    #1;
    check({got[3], got[2], got[1], got[0]}, 16'h1010);
    check(port_rx_nibble, 16'h0000);
    @(posedge clock);
    excess_collision_drop <= 1'b1;
    tx_frame_start <= 1'b1;
    @(posedge clock);
    tx_frame_start <= 1'b0;
    for (i = 1; i <= 16; i = i + 1) begin
      @(posedge clock);
      tx_collision <= 1'b1;
      carrier_sense <= i[0];
      @(posedge clock);
      tx_collision <= 1'b0;
      #1;
      for (t0 = 0; t0 < 9000 && backoff_active !== 1'b0; t0 = t0 + 1) #5;
      check(t0 < 7700, 16'h0001);
      if (i < 16) check(backoff_carrier_seen, i[0]);
      if (i == 15) check(nd, 16'h0000);
    end
    repeat (3) @(posedge clock);
    #1;
    check(nd, 16'h0001);
    check(core_tx_valid, 16'h0000);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(flags, 16'h00b3);
    stop_test;
  end
endmodule // smp_port_bench
`default_nettype wire

/* tb/smp_port_chk.sv */
// checker for smp_port: pin enables, port clock, straps, drop and backoff
// assumes it is bound onto smp_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module smp_port_chk #(
  parameter BCAST_THRESHOLD = 8,
  parameter QCOUNT_W = 8
) (
  input wire clock,
  input wire rst_n,
  input wire external_port_enable,
  input wire serial_mode,
  input wire direct_led_mode,
  input wire broadcast_limit_enable,
  input wire excess_collision_drop,
  input wire eeprom_serial_clock,
  input wire eeprom_serial_clock_oe,
  input wire [3:0] port_rx_nibble_oe,
  input wire port_collision_out_oe,
  input wire port4_link_led_oe,
  input wire port5_link_led_oe,
  input wire rx_is_broadcast,
  input wire rx_frame_start,
  input wire [QCOUNT_W-1:0] bcast_queued,
  input wire rx_drop,
  input wire tx_collision,
  input wire tx_discard,
  input wire backoff_active,
  input wire backpressure_enable,
  input wire [1:0] backpressure_type,
  input wire flow_control_enable,
  input wire aggressive_backoff,
  input wire test_pass,
  input wire backpressure_carrier,
  input wire carrier_window_fixed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================
  // pins and straps
  // port on and mode unchanged long enough for the enables to follow
  sequence settled;
    external_port_enable && $past(external_port_enable) && $past(rst_n, 3)
      && (serial_mode == $past(serial_mode));
  endsequence
  clk_half_a: assert property ($fell(eeprom_serial_clock) && external_port_enable
    && $past(external_port_enable, 5)
    |-> $past(eeprom_serial_clock, 4) && !$past(eeprom_serial_clock, 5))
    else $error("port clock half period wrong");
  pin_oe_a: assert property (settled |-> eeprom_serial_clock_oe
    && port_rx_nibble_oe == (serial_mode ? 4'h1 : 4'hf))
    else $error("rx pin enables wrong");
  col_oe_a: assert property (settled |-> port_collision_out_oe == !serial_mode)
    else $error("collision pin enable wrong");
  led_oe_a: assert property ($past(rst_n, 3) && $stable(direct_led_mode)
    |-> port4_link_led_oe == direct_led_mode && port5_link_led_oe == direct_led_mode)
    else $error("led pin enables wrong");
  strap_hold_a: assert property ($past(rst_n) && $past(rst_n, 2)
    |-> $stable({backpressure_enable, backpressure_type, flow_control_enable,
    aggressive_backoff, test_pass}))
    else $error("strap outputs moved");
  carrier_only_a: assert property ((backpressure_carrier == backpressure_enable)
    && carrier_window_fixed)
    else $error("fixed backpressure flags low");
  bcast_drop_a: assert property (rx_frame_start |=> rx_drop ==
    $past(broadcast_limit_enable && rx_is_broadcast && bcast_queued > BCAST_THRESHOLD))
    else $error("broadcast drop wrong");
  discard_cause_a: assert property (tx_discard |->
    $past(tx_collision) && $past(excess_collision_drop))
    else $error("discard without cause");
  backoff_start_a: assert property (tx_collision |=> backoff_active || tx_discard)
    else $error("backoff did not start");
endmodule // smp_port_chk

bind smp_port smp_port_chk #(.BCAST_THRESHOLD(BCAST_THRESHOLD), .QCOUNT_W(QCOUNT_W)) chk (.*);
`default_nettype wire

/* verilog/smp_backoff.v */
// backoff slot limiter with pseudo-random draw
// assumes attempt strobes come from the core clock domain
`timescale 1ns/1ps
`default_nettype none
module smp_backoff (
  input wire clock,
  input wire rst_n,
  input wire aggressive,
  input wire draw,
  input wire [4:0] attempt,
  output reg [10:0] slots
);
  reg [15:0] lfsr;
  reg [10:0] mask;
  always @* begin
    if (attempt >= 5'h0a)
      mask = 11'h3ff;
    else
      mask = (11'h001 << attempt) - 11'h001;
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      lfsr <= 16'hace1;
      slots <= 11'h000;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      if (draw) begin
        if (aggressive)
          slots <= {7'h00, lfsr[3:0] & mask[3:0] & 4'h7};
        else
          slots <= lfsr[10:0] & mask;
      end
    end
  end
endmodule // smp_backoff
`default_nettype wire

/* verilog/smp_port.v */
// external port 0 of the switch with strap capture
// assumes a 200 MHz clock; port clock made by division and driven out
`timescale 1ns/1ps
`default_nettype none
`include "smp_regs.vh"
module smp_port #(
  parameter BCAST_THRESHOLD = 8,
  parameter QCOUNT_W = 8
) (
  input wire clock,
  input wire rst_n,
  input wire external_port_enable,
  input wire serial_mode,
  input wire direct_led_mode,
  input wire broadcast_limit_enable,
  input wire excess_collision_drop,
  // strap pins, sampled as inputs
  input wire backpressure_enable_strap_in,
  input wire [1:0] backpressure_type_strap_in,
  input wire flow_strap_in,
  input wire aggressive_backoff_strap_in,
  input wire test_pass_strap_in,
  // shared pin drivers
  output reg eeprom_serial_clock,
  output wire eeprom_serial_clock_oe,
  input wire eeprom_data_in,
  output reg [3:0] port_rx_nibble,
  output wire [3:0] port_rx_nibble_oe,
  output reg port_rx_valid,
  output wire port_rx_valid_oe,
  output reg port_collision_out,
  output wire port_collision_out_oe,
  output reg port4_link_led,
  output wire port4_link_led_oe,
  output reg port5_link_led,
  output wire port5_link_led_oe,
  input wire port_tx_enable_in,
  input wire [3:0] port_tx_nibble,
  // core side
  input wire [3:0] core_rx_nibble,
  input wire core_rx_valid,
  input wire core_collision,
  input wire port4_link,
  input wire port5_link,
  output reg [3:0] core_tx_nibble,
  output reg core_tx_valid,
  output reg core_tx_strobe,
  input wire rx_is_broadcast,
  input wire rx_frame_start,
  input wire [QCOUNT_W-1:0] bcast_queued,
  output reg rx_drop,
  input wire tx_collision,
  input wire tx_frame_start,
  input wire carrier_sense,
  output reg tx_discard,
  output reg backoff_active,
  output reg backoff_carrier_seen,
  output wire backpressure_enable,
  output wire [1:0] backpressure_type,
  output wire backpressure_carrier,
  output wire flow_control_enable,
  output wire aggressive_backoff,
  output wire test_pass,
  output wire carrier_window_fixed
);
  // ==========================================
  // strap capture
  reg in_reset;
  reg [`SMP_STRAP_W-1:0] strap;
  wire [`SMP_STRAP_W-1:0] strap_pins;
  assign strap_pins = {test_pass_strap_in, aggressive_backoff_strap_in, flow_strap_in,
                       backpressure_type_strap_in, backpressure_enable_strap_in};
  always @(posedge clock) begin
    if (!rst_n) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= 1'b0;
    end
  end
  // catch at first edge after release, pins still inputs then
  always @(posedge clock) begin
    if (!rst_n)
      strap <= `SMP_STRAP_RESET;
    else if (in_reset)
      strap <= strap_pins;
  end
  assign backpressure_enable = strap[`SMP_STRAP_BKP_EN];
  assign backpressure_type = strap[`SMP_STRAP_BKP_TYPE_HI:`SMP_STRAP_BKP_TYPE_LO];
  // every backpressure type code gives carrier backpressure when enabled
  assign backpressure_carrier = backpressure_enable;
  assign flow_control_enable = strap[`SMP_STRAP_FLOW];
  assign aggressive_backoff = strap[`SMP_STRAP_AGGR];
  assign test_pass = strap[`SMP_STRAP_TEST];
  assign carrier_window_fixed = 1'b1;
  // ==========================================
  // pin direction
  wire port_on;
  assign port_on = external_port_enable & ~in_reset;
  assign eeprom_serial_clock_oe = port_on;
  assign port_rx_nibble_oe = serial_mode ? {3'h0, port_on} : {4{port_on}};
  assign port_rx_valid_oe = port_on;
  assign port_collision_out_oe = port_on & ~serial_mode;
  assign port4_link_led_oe = direct_led_mode & ~in_reset;
  assign port5_link_led_oe = direct_led_mode & ~in_reset;
  // ==========================================
  // port clock generation
  reg [1:0] div;
  reg clk_rise;
  reg clk_fall;
  always @(posedge clock) begin
    if (!rst_n) begin
      div <= 2'h0;
      eeprom_serial_clock <= 1'b0;
      clk_rise <= 1'b0;
      clk_fall <= 1'b0;
    end else begin
      clk_rise <= 1'b0;
      clk_fall <= 1'b0;
      if (div == `SMP_CLK_HALF_DIV) begin
        div <= 2'h0;
        eeprom_serial_clock <= ~eeprom_serial_clock;
        clk_rise <= ~eeprom_serial_clock;
        clk_fall <= eeprom_serial_clock;
      end else begin
        div <= div + 2'h1;
      end
    end
  end
  // ==========================================
  // receive toward partner, launched at falling edge
  always @(posedge clock) begin
    if (!rst_n) begin
      port_rx_nibble <= 4'h0;
      port_rx_valid <= 1'b0;
      port_collision_out <= 1'b0;
      port4_link_led <= 1'b0;
      port5_link_led <= 1'b0;
    end else begin
      port4_link_led <= port4_link;
      port5_link_led <= port5_link;
      if (clk_fall) begin
        port_rx_valid <= core_rx_valid;
        port_collision_out <= core_collision;
        if (serial_mode)
          port_rx_nibble <= {3'h0, core_rx_nibble[0]};
        else
          port_rx_nibble <= core_rx_nibble;
      end
    end
  end
  // ==========================================
  // transmit from partner, sampled at rising edge
  wire tx_en_s;
  wire [3:0] tx_d_s;
  smp_sync2 u_sync_en (.clock(clock), .rst_n(rst_n), .din(port_tx_enable_in), .dout(tx_en_s));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_txd
      smp_sync2 u_sync_d (.clock(clock), .rst_n(rst_n), .din(port_tx_nibble[gi]),
                          .dout(tx_d_s[gi]));
    end
  endgenerate
  always @(posedge clock) begin
    if (!rst_n) begin
      core_tx_nibble <= 4'h0;
      core_tx_valid <= 1'b0;
      core_tx_strobe <= 1'b0;
    end else begin
      core_tx_strobe <= 1'b0;
      if (clk_rise & port_on) begin
        core_tx_valid <= tx_en_s;
        core_tx_strobe <= tx_en_s;
        core_tx_nibble <= serial_mode ? {3'h0, tx_d_s[0]} : tx_d_s;
      end
    end
  end
  // ==========================================
  // broadcast storm limit
  always @(posedge clock) begin
    if (!rst_n)
      rx_drop <= 1'b0;
    else if (rx_frame_start)
      rx_drop <= broadcast_limit_enable & rx_is_broadcast &
                 (bcast_queued > BCAST_THRESHOLD[QCOUNT_W-1:0]);
  end
  // ==========================================
  // collision count and backoff
  localparam ST_IDLE = 2'h0;
  localparam ST_BACKOFF = 2'h1;
  localparam ST_SENSE = 2'h2;
  reg [1:0] state;
  reg [4:0] attempts;
  reg [10:0] slot_left;
  reg [9:0] slot_timer;
  reg [6:0] sense_bits;
  reg draw;
  wire [10:0] slots;
  smp_backoff u_backoff (.clock(clock), .rst_n(rst_n), .aggressive(aggressive_backoff),
                         .draw(draw), .attempt(attempts), .slots(slots));
  // one bit time at 100M is 2 cycles of the 200 MHz core clock
  always @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      attempts <= 5'h00;
      slot_left <= 11'h000;
      slot_timer <= 10'h000;
      sense_bits <= 7'h00;
      draw <= 1'b0;
      tx_discard <= 1'b0;
      backoff_active <= 1'b0;
      backoff_carrier_seen <= 1'b0;
    end else begin
      draw <= 1'b0;
      tx_discard <= 1'b0;
      case (state)
        ST_IDLE: begin
          backoff_active <= 1'b0;
          if (tx_frame_start & ~tx_collision)
            attempts <= 5'h00;
          if (tx_collision) begin
            if (excess_collision_drop & (attempts + 5'h01 == `SMP_EXCESS_COLL)) begin
              tx_discard <= 1'b1;
              attempts <= 5'h00;
            end else begin
              // without drop, keep retrying and saturate count
              if (attempts != 5'h1f)
                attempts <= attempts + 5'h01;
              draw <= 1'b1;
              state <= ST_BACKOFF;
              backoff_active <= 1'b1;
              slot_timer <= 10'h000;
            end
          end
        end
        ST_BACKOFF: begin
          if (draw)
            slot_left <= 11'h000;
          else if (slot_left == 11'h000 && slot_timer == 10'h000 && !draw) begin
            slot_left <= slots;
            slot_timer <= 10'h3ff;
            if (slots == 11'h000) begin
              state <= ST_SENSE;
              sense_bits <= 7'h00;
            end
          end else if (slot_timer != 10'h000) begin
            slot_timer <= slot_timer - 10'h001;
          end else begin
            slot_left <= slot_left - 11'h001;
            slot_timer <= 10'h3ff;
            if (slot_left == 11'h001) begin
              state <= ST_SENSE;
              sense_bits <= 7'h00;
            end
          end
        end
        ST_SENSE: begin
          if (clk_rise) begin
            sense_bits <= sense_bits + 7'h01;
            backoff_carrier_seen <= carrier_sense;
            if (sense_bits + 7'h01 == `SMP_CARRIER_SENSE_BITS) begin
              state <= ST_IDLE;
              backoff_active <= 1'b0;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // smp_port
`default_nettype wire

/* verilog/smp_sync2.v */
// two-flop synchroniser for one level
// assumes the input is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module smp_sync2 (
  input wire clock,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg stage1;
  always @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // smp_sync2
`default_nettype wire
